// >>> fpe_consts.svh
// offsets, field positions, command codes and timing counts
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH

// register byte offsets on the apb side
`define FPE_OFF_CTRL     8'h00
`define FPE_OFF_ADDR     8'h04
`define FPE_OFF_DATA     8'h08
`define FPE_OFF_COUNT    8'h0C
`define FPE_OFF_STATUS   8'h10
`define FPE_OFF_RDATA    8'h14

// control register fields
`define FPE_CTRL_START   0
`define FPE_CTRL_OP_LO   1
`define FPE_CTRL_OP_HI   3
`define FPE_CTRL_ALT     4

// flash status byte bit positions
`define FPE_SR_READY     7
`define FPE_SR_ERASE_ERR 5
`define FPE_SR_PROG_ERR  4
`define FPE_SR_LOW_VOLT  3
`define FPE_SR_PSUSP     2
`define FPE_SR_LOCKED    1
`define FPE_XSR_FREE     7

// flash pin widths
`define FPE_AW           24
`define FPE_DW           16

// single program setup codes
`define FPE_CMD_PROG     8'h40
`define FPE_CMD_PROG_ALT 8'h10

// buffer boundary: low five address bits
`define FPE_ALIGN_BITS   5

// strobe timing, ns and derived cycles at 125 MHz (8 ns), least times round up
`define FPE_CLK_NS       8
`define FPE_T_STROBE_NS  72
`define FPE_T_GAP_NS     32
`define FPE_STROBE_CYC   ((`FPE_T_STROBE_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`define FPE_GAP_CYC      ((`FPE_T_GAP_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)

`endif

// >>> fpe_pkg.sv
// types shared by the flash program/erase host controller
package fpe_pkg;
  `include "fpe_consts.svh"

  // operations software can start
  typedef enum logic [2:0] {
    FPE_OP_PROGRAM,
    FPE_OP_BUFFER,
    FPE_OP_ERASE,
    FPE_OP_SUSPEND,
    FPE_OP_RESUME,
    FPE_OP_CLEAR
  } fpe_op_t;

  // pins driven toward the flash
  typedef struct packed {
    logic [`FPE_AW-1:0] addr;
    logic [`FPE_DW-1:0] dq_out;
    logic               dq_oe;
    logic               chip_select_0_b;
    logic               oe_b;
    logic               we_b;
  } fpe_pins_t;

  // one bus cycle request toward the flash
  typedef struct packed {
    logic               rd;
    logic [`FPE_AW-1:0] addr;
    logic [`FPE_DW-1:0] data;
  } fpe_cyc_t;
endpackage

// >>> fpe_cycle.sv
// one asynchronous flash write or read cycle, with strobe timing and input sync
`include "fpe_consts.svh"
module fpe_cycle
  import fpe_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               req,
  input  wire fpe_cyc_t           cyc,
  output logic                    done,
  output logic [`FPE_DW-1:0]      rdata,
  output fpe_pins_t               pins,
  input  wire logic [`FPE_DW-1:0] dq_in
);
  localparam int CW = 8;
  localparam logic [CW-1:0] STROBE = CW'(`FPE_STROBE_CYC);
  localparam logic [CW-1:0] GAP    = CW'(`FPE_GAP_CYC);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_GAP} fpe_cst_t;

  fpe_cst_t           st;
  logic [CW-1:0]      cnt;
  logic [`FPE_DW-1:0] dq_s1;
  logic [`FPE_DW-1:0] dq_s2;

  wire strobe_end = (st == C_STROBE) && (cnt == STROBE - CW'(1));
  wire gap_end    = (st == C_GAP) && (cnt == GAP - CW'(1));

  // data pins cross two flops before sampling
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end

  // setup, strobe low, then a gap with we and oe high; chip select rises one cycle into the gap
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      st    <= C_IDLE;
      cnt   <= '0;
      done  <= 1'b0;
      rdata <= '0;
      pins  <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, chip_select_0_b: 1'b1,
                 oe_b: 1'b1, we_b: 1'b1};
    end
    else
    begin
      done <= 1'b0;
      cnt  <= cnt + CW'(1);
      case (st)
        C_IDLE:
          if (req)
          begin
            pins.addr            <= cyc.addr;
            pins.dq_out          <= cyc.data;
            pins.dq_oe           <= !cyc.rd;
            pins.chip_select_0_b <= 1'b0;
            st                   <= C_SETUP;
          end
        C_SETUP:
        begin
          pins.oe_b <= !cyc.rd;
          pins.we_b <= cyc.rd;
          cnt       <= '0;
          st        <= C_STROBE;
        end
        C_STROBE:
          if (strobe_end)
          begin
            // rising write strobe latches address and data in the flash [R1]
            pins.we_b <= 1'b1;
            // oe rises every read so the next status poll is refreshed [R22]
            pins.oe_b <= 1'b1;
            rdata     <= dq_s2;
            cnt       <= '0;
            st        <= C_GAP;
          end
        C_GAP:
        begin
          pins.dq_oe           <= 1'b0;
          pins.chip_select_0_b <= 1'b1;
          if (gap_end)
          begin
            done <= 1'b1;
            st   <= C_IDLE;
          end
        end
        default:
          st <= C_IDLE;
      endcase
    end
endmodule

// >>> fpe_ctrl.sv
// host controller that programs, erases and suspends an external nor flash over apb
// Function
// R1: program is setup code then address/data write
// R2: poll status until machine ready after program
// R3: status reads continue until another command
// R4: verify error shown only through program fail
// R5: program aborts on low supply or lock
// R6: repeat buffer setup until buffer free
// R7: send count, then start address and data
// R8: start address best aligned to buffer boundary
// R9: confirm after buffer data, else sequence error
// R10: buffer error stops write, program fail set
// R11: no buffered write while fail flags set
// R12: buffer crossing block boundary is sequence error
// R13: buffered write aborts on low supply or lock
// R14: suspend halts; ready and suspended flags set
// R15: while suspended only few commands allowed
// R16: resume continues, flags clear, status reads
// R17: resume accepted at any address
// R18: nested suspend needs two resumes, two levels
// R19: erased block reads all ones
// R20: erase is setup then confirm in block
// R21: erase error flag combinations reported
// R22: toggle output enable between status polls
// R23: both fail flags mean bad sequence
// R24: undisclosed command codes are parameters
//
// The APB register port and the address map are this design's own decisions.
`include "fpe_consts.svh"
module fpe_ctrl
  import fpe_pkg::*;
#(
  parameter logic [7:0] CMD_BUF_SETUP   = 8'hA0,
  parameter logic [7:0] CMD_CONFIRM     = 8'hA1,
  parameter logic [7:0] CMD_ERASE_SETUP = 8'hA2,
  parameter logic [7:0] CMD_SUSPEND     = 8'hA3,
  parameter logic [7:0] CMD_RESUME      = 8'hA4,
  parameter logic [7:0] CMD_CLEAR       = 8'hA5,
  parameter int         BLOCK_BITS      = 17
)
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output fpe_pins_t               flash_pins,
  input  wire logic [`FPE_DW-1:0] flash_dq_in,
  input  wire logic               ready_status_pin
);
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_XSR, S_COUNT, S_WAIT, S_DATA, S_CONF, S_POLL
  } fpe_st_t;

  fpe_st_t            st;
  fpe_op_t            op;
  logic               alt;
  logic [`FPE_AW-1:0] addr;
  logic [`FPE_AW-1:0] cur_addr;
  logic [`FPE_DW-1:0] wdata;
  logic               data_pend;
  logic [`FPE_DW-1:0] count;
  logic [`FPE_DW-1:0] remain;
  logic [7:0]         status;
  logic [`FPE_DW-1:0] last_rd;
  logic               refused;
  logic               misaligned;
  logic               rdy_s1;
  logic               rdy_s2;
  logic               cyc_busy;
  logic               cyc_done;
  logic [`FPE_DW-1:0] cyc_rdata;
  fpe_cyc_t           cyc;

  // apb decode, always ready with no wait states
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_ctrl = paddr == `FPE_OFF_CTRL;
  wire hit_addr = paddr == `FPE_OFF_ADDR;
  wire hit_data = paddr == `FPE_OFF_DATA;
  wire hit_cnt  = paddr == `FPE_OFF_COUNT;
  wire hit_stat = paddr == `FPE_OFF_STATUS;
  wire hit_rd   = paddr == `FPE_OFF_RDATA;
  wire mapped   = hit_ctrl | hit_addr | hit_data | hit_cnt | hit_stat | hit_rd;
  wire busy     = st != S_IDLE;
  wire start    = wr && hit_ctrl && pwdata[`FPE_CTRL_START] && !busy;
  wire fpe_op_t start_op = fpe_op_t'(pwdata[`FPE_CTRL_OP_HI:`FPE_CTRL_OP_LO]);

  // a buffered write is refused while a fail flag stands [R11]
  wire fail_set = status[`FPE_SR_PROG_ERR] || status[`FPE_SR_ERASE_ERR];
  // last word must stay inside the same erase block [R12]
  wire [`FPE_AW-1:0] end_addr = addr + `FPE_AW'(count) - `FPE_AW'(1);
  wire crosses = end_addr[`FPE_AW-1:BLOCK_BITS] != addr[`FPE_AW-1:BLOCK_BITS];
  wire refuse  = (start_op == FPE_OP_BUFFER) && (fail_set || crosses || count == '0);

  // both fail flags together mean an improper sequence [R23]
  wire seq_err = status[`FPE_SR_PROG_ERR] && status[`FPE_SR_ERASE_ERR];

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // read mux; reserved bits read zero
  always_comb
  begin
    prdata = '0;
    if (hit_ctrl)
      prdata = {27'h0, alt, op, 1'b0};
    else if (hit_addr)
      prdata = {8'h00, addr};
    else if (hit_data)
      prdata = {16'h0000, wdata};
    else if (hit_cnt)
      prdata = {16'h0000, count};
    else if (hit_stat)
      prdata = {16'h0000, status, seq_err, misaligned, refused, rdy_s2,
                data_pend, 2'b00, busy};
    else if (hit_rd)
      prdata = {16'h0000, last_rd};
  end

  // command selection for the first write of each operation
  function automatic logic [7:0] first_cmd(input fpe_op_t o, input logic a);
    case (o)
      FPE_OP_PROGRAM: first_cmd = a ? `FPE_CMD_PROG_ALT : `FPE_CMD_PROG; // [R1]
      FPE_OP_BUFFER:  first_cmd = CMD_BUF_SETUP;   // [R6] [R24]
      FPE_OP_ERASE:   first_cmd = CMD_ERASE_SETUP; // [R20] [R24]
      FPE_OP_SUSPEND: first_cmd = CMD_SUSPEND;     // [R14] [R24]
      FPE_OP_RESUME:  first_cmd = CMD_RESUME;      // [R16] [R18] [R24]
      default:        first_cmd = CMD_CLEAR;
    endcase
  endfunction

  // cycle request for the current state; resume goes to address zero [R17]
  always_comb
  begin
    cyc = '{rd: 1'b0, addr: addr, data: `FPE_DW'(first_cmd(op, alt))};
    case (st)
      S_CMD1:
        if (op == FPE_OP_RESUME)
          cyc.addr = '0;
      S_XSR:   cyc.rd = 1'b1;
      S_COUNT: cyc.data = count;
      S_DATA:  cyc = '{rd: 1'b0, addr: cur_addr, data: wdata};
      S_CONF:  cyc.data = `FPE_DW'(CMD_CONFIRM);
      S_POLL:  cyc.rd = 1'b1;
      default: cyc.rd = 1'b0;
    endcase
  end

  wire cyc_req = busy && st != S_WAIT && !cyc_busy;

  // ready pin is asynchronous to this clock
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end
    else
    begin
      rdy_s1 <= ready_status_pin;
      rdy_s2 <= rdy_s1;
    end

  // software-written registers
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      alt   <= 1'b0;
      addr  <= '0;
      count <= '0;
      wdata <= '0;
    end
    else if (wr && !busy)
    begin
      if (hit_ctrl)
        alt <= pwdata[`FPE_CTRL_ALT];
      if (hit_addr)
        addr <= pwdata[`FPE_AW-1:0];
      if (hit_cnt)
        count <= pwdata[`FPE_DW-1:0];
      if (hit_data)
        wdata <= pwdata[`FPE_DW-1:0];
    end
    else if (wr && hit_data && !data_pend)
      wdata <= pwdata[`FPE_DW-1:0];

  // cycle issue tracking
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      cyc_busy <= 1'b0;
    else if (cyc_done)
      cyc_busy <= 1'b0;
    else if (cyc_req)
      cyc_busy <= 1'b1;

  // operation sequencer
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      st         <= S_IDLE;
      op         <= FPE_OP_PROGRAM;
      cur_addr   <= '0;
      remain     <= '0;
      status     <= '0;
      last_rd    <= '0;
      refused    <= 1'b0;
      misaligned <= 1'b0;
      data_pend  <= 1'b0;
    end
    else
    begin
      // a buffer word may be queued from setup on; else an early word is lost
      if (wr && hit_data && op == FPE_OP_BUFFER &&
          (st == S_CMD1 || st == S_XSR || st == S_COUNT || st == S_WAIT))
        data_pend <= 1'b1;
      if (start)
      begin
        op      <= start_op;
        refused <= refuse;
        // flag an unaligned buffer start, speed only [R8]
        misaligned <= (start_op == FPE_OP_BUFFER) && (addr[`FPE_ALIGN_BITS-1:0] != '0);
        cur_addr   <= addr;
        remain     <= count;
        data_pend  <= 1'b0;
        if (!refuse)
          st <= S_CMD1;
      end
      if (cyc_done)
      begin
        last_rd <= cyc_rdata;
        case (st)
          S_CMD1:
            case (op)
              FPE_OP_PROGRAM: st <= S_DATA;
              FPE_OP_BUFFER:  st <= S_XSR;
              FPE_OP_ERASE:   st <= S_CONF;
              FPE_OP_CLEAR:
              begin
                status <= '0;
                st     <= S_IDLE;
              end
              default:        st <= S_POLL;
            endcase
          // retry the setup until the buffer is free [R6]
          S_XSR:
            st <= cyc_rdata[`FPE_XSR_FREE] ? S_COUNT : S_CMD1;
          // count first, data words follow [R7]
          S_COUNT:
            st <= S_WAIT;
          S_DATA:
            if (op == FPE_OP_PROGRAM)
              st <= S_POLL; // [R2]
            else
            begin
              data_pend <= 1'b0;
              remain    <= remain - `FPE_DW'(1);
              cur_addr  <= cur_addr + `FPE_AW'(1);
              // confirm right after the last word, nothing else between [R9]
              st <= (remain == `FPE_DW'(1)) ? S_CONF : S_WAIT;
            end
          S_CONF:
            st <= S_POLL;
          // every poll is its own oe pulse; done once machine ready [R2] [R22]
          S_POLL:
          begin
            status <= cyc_rdata[7:0];
            if (cyc_rdata[`FPE_SR_READY])
              st <= S_IDLE;
          end
          default:
            st <= S_IDLE;
        endcase
      end
      else if (st == S_WAIT && data_pend)
        st <= S_DATA;
    end

  fpe_cycle u_cycle (
    .clock (clock),
    .rst_b (rst_b),
    .req   (cyc_req),
    .cyc   (cyc),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (flash_pins),
    .dq_in (flash_dq_in)
  );
endmodule

// >>> fpe_chk.sv
// port assertions for the flash program/erase host controller
module fpe_chk
  import fpe_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire fpe_pins_t  flash_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // named views of the strobes, active high
  wire logic acc = psel && penable;
  wire logic we  = !flash_pins.we_b;
  wire logic rd  = !flash_pins.oe_b;
  wire logic cs  = !flash_pins.chip_select_0_b;
  // a strobe stays low nine cycles, then lets go
  sequence s_we_hold;
    we [*8] ##1 !we;
  endsequence
  sequence s_rd_hold;
    rd [*8] ##1 !rd;
  endsequence
  a_apb_ready: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (acc && paddr > 8'h14 |-> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  a_we_width: assert property ($fell(flash_pins.we_b) |=> s_we_hold)
    else $error("write strobe width");
  a_rd_width: assert property ($fell(flash_pins.oe_b) |=> s_rd_hold)
    else $error("read strobe width");
  a_we_drives: assert property (we |-> flash_pins.dq_oe && cs && !rd)
    else $error("write strobe without drive");
  a_rd_float: assert property (rd |-> !flash_pins.dq_oe && cs)
    else $error("host drives during read");
  a_we_stable: assert property (we && $past(we) |-> $stable(flash_pins.addr)
    && $stable(flash_pins.dq_out))
    else $error("addr or data moved in strobe");
  a_poll_gap: assert property ($rose(flash_pins.oe_b) |-> !rd [*4])
    else $error("output enable not toggled");
endmodule

bind fpe_ctrl fpe_chk i_chk (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins));

// >>> fpe_flash_mdl.sv
// behavioural nor flash command and status model
module fpe_flash_mdl
  import fpe_pkg::*;
#(
  parameter logic [7:0] BUF  = 8'hA0,
  parameter logic [7:0] CONF = 8'hA1,
  parameter logic [7:0] ERS  = 8'hA2,
  parameter logic [7:0] SUS  = 8'hA3,
  parameter logic [7:0] RES  = 8'hA4,
  parameter logic [7:0] CLR  = 8'hA5,
  parameter int         BUSY = 40
)
(
  input  wire logic       clock,
  input  wire fpe_pins_t  pins,
  input  wire logic       program_enable_supply_low,
  input  wire logic       locked,
  output logic [15:0]     dq,
  output logic            ready_status_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sr   = 7'h00;
  logic [7:0] extended_status  = 8'h00;
  logic [7:0] snap = 8'h80;
  logic       xm   = 1'b0;
  logic       susp = 1'b0;
  logic       free = 1'b0;
  int         st   = 0;
  int         n    = 0;
  int         bc   = 0;
  int         p;
  wire logic [7:0] c = pins.dq_out[7:0];
  // machine runs on its own, halted while suspended
  always @(posedge clock)
    if (bc > 0 && !susp)
      bc <= bc - 1;
  // abort on low supply or lock, else start
  // a verify or copy fault would only raise program fail; not modelled
  task automatic run(input logic [6:0] lo, input logic [6:0] lk);
    if (program_enable_supply_low)
      sr |= lo;
    else if (locked)
      sr |= lk;
    else
      bc = BUSY;
  endtask
  // commands latch on the write strobe rising edge
  always @(posedge pins.we_b)
    if (!pins.chip_select_0_b)
    begin
      p = st;
      xm = 1'b0;
      case (p)
        1: run(7'h18, 7'h12);
        2: if (c != CONF) sr |= 7'h30; else run(7'h28, 7'h22);
        3: n = int'(pins.dq_out);
        4: n = n - 1;
        5: if (c != CONF) sr |= 7'h30; else run(7'h18, 7'h12);
        default:
          if ((c == 8'h40 || c == 8'h10) && !susp) st = 1;
          else if (c == ERS && !susp) st = 2;
          else if (c == BUF && sr[5:4] == 2'h0 && !susp)
          begin
            xm = 1'b1;
            extended_status = {free, 7'h00};
            st = free ? 3 : 0;
            free = !free;
          end
          else if (c == SUS && bc > 0) {susp, sr[2]} = 2'h3;
          else if (c == RES) {susp, sr[2]} = 2'h0;
          else if (c == CLR) sr = 7'h00;
      endcase
      if (p == 3) st = 4;
      else if (p == 4) st = n > 0 ? 4 : 5;
      else if (p != 0) st = 0;
    end
  // status freezes until output enable toggles
  always @(negedge pins.oe_b)
    snap = xm ? extended_status : {bc == 0 || susp, sr};
  // a released bus shows the inverse so a stale value cannot pass
  assign dq = (!pins.oe_b && !pins.chip_select_0_b) ? {8'h00, snap} : {8'hFF, ~snap};
  assign ready_status_pin = bc == 0 || susp;
endmodule

// >>> tb.sv
// self-checking bench for the flash program/erase host controller
`include "fpe_consts.svh"
module tb
  import fpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, err, rdy, program_enable_supply_low = 0, locked = 0;
  logic [15:0] dq;
  logic [23:0] wadr;
  logic [15:0] cmds [$];
  fpe_pins_t   pins;
  int          bad_count = 0, checked = 0;
  always #4 clock = ~clock;
  fpe_ctrl i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_pins(pins), .flash_dq_in(dq), .ready_status_pin(rdy));
  fpe_flash_mdl i_mdl (.clock(clock), .pins(pins), .program_enable_supply_low(program_enable_supply_low), .locked(locked),
    .dq(dq), .ready_status_pin(rdy));
  // log every word written to the flash
  always @(posedge pins.we_b)
    if (!pins.chip_select_0_b)
    begin
      cmds.push_back(pins.dq_out);
      wadr = pins.addr;
    end
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // poll busy with a bound; a stuck controller fails the compare
  task automatic idle();
    for (int i = 0; i < 400; i++)
    begin
      apb(0, `FPE_OFF_STATUS, 0);
      if (r[0] === 1'b0)
        break;
    end
    chk(32'(r[0]), 0);
  endtask
  task automatic sb(input logic [7:0] e);
    apb(0, `FPE_OFF_STATUS, 0);
    chk(32'(r[15:8]), 32'(e));
  endtask
  task automatic op(input logic [23:0] a, input logic [31:0] ctl);
    cmds.delete();
    apb(1, `FPE_OFF_ADDR, 32'(a));
    apb(1, `FPE_OFF_CTRL, ctl);
    idle();
  endtask
  task automatic t_prog(input logic alt);
    apb(1, `FPE_OFF_DATA, 32'h0000_1234);
    op(24'h000100, alt ? 32'h11 : 32'h01);
    chk(32'(cmds[0]), alt ? 32'h10 : 32'h40);
    chk(32'(cmds[1]), 32'h1234);
    chk(32'(wadr), 32'h100);
    sb(8'h80);
    apb(0, `FPE_OFF_RDATA, 0);
    chk(r, 32'h80);
  endtask
  // abort flags, then a buffered write is refused until cleared
  task automatic t_abort(input logic [31:0] ctl, input logic lv, input logic [7:0] e);
    program_enable_supply_low <= lv;
    locked <= !lv;
    op(24'h000200, ctl);
    sb(e);
    apb(1, `FPE_OFF_COUNT, 1);
    apb(1, `FPE_OFF_CTRL, 32'h03);
    apb(0, `FPE_OFF_STATUS, 0);
    chk(32'(r[5]), 1);
    op(24'h0, 32'h0B);
    program_enable_supply_low <= 0;
    locked <= 0;
  endtask
  task automatic t_buffer();
    logic [15:0] e [6];
    e = '{16'h00A0, 16'h00A0, 16'h0002, 16'hAAAA, 16'h5555, 16'h00A1};
    cmds.delete();
    apb(1, `FPE_OFF_ADDR, 32'h20);
    apb(1, `FPE_OFF_COUNT, 2);
    apb(1, `FPE_OFF_CTRL, 32'h03);
    for (int w = 3; w < 5; w++)
    begin
      for (int i = 0; i < 200 && r[3] !== 1'b0; i++)
        apb(0, `FPE_OFF_STATUS, 0);
      apb(1, `FPE_OFF_DATA, 32'(e[w]));
      r[3] = 1'b1;
    end
    idle();
    chk(32'(r[6]), 0);
    foreach (e[i])
      chk(32'(cmds[i]), 32'(e[i]));
    sb(8'h80);
  endtask
  task automatic t_cross();
    cmds.delete();
    apb(1, `FPE_OFF_ADDR, 32'h01FFFF);
    apb(1, `FPE_OFF_COUNT, 2);
    apb(1, `FPE_OFF_CTRL, 32'h03);
    idle();
    apb(0, `FPE_OFF_STATUS, 0);
    chk(32'(r[5]), 1);
    chk(32'(r[6]), 1);
    chk(32'(cmds.size()), 0);
  endtask
  task automatic t_erase();
    op(24'h040000, 32'h05);
    chk(32'(cmds[0]), 32'hA2);
    chk(32'(cmds[1]), 32'hA1);
    chk(32'(wadr), 32'h040000);
    sb(8'h80);
    chk(32'(r[4]), 1);
  endtask
  // suspend, then resume twice as a nested pair would need
  task automatic t_susp();
    op(24'h123456, 32'h07);
    chk(32'(cmds[0]), 32'hA3);
    for (int k = 0; k < 2; k++)
    begin
      op(24'h123456, 32'h09);
      chk(32'(cmds[0]), 32'hA4);
      chk(32'(wadr), 0);
      sb(8'h80);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    rst_b <= 1;
    t_prog(0);
    t_prog(1);
    t_abort(32'h01, 1, 8'h98);
    t_abort(32'h01, 0, 8'h92);
    t_abort(32'h05, 1, 8'hA8);
    t_abort(32'h05, 0, 8'hA2);
    t_buffer();
    t_cross();
    t_erase();
    t_susp();
    apb(0, 8'h40, 0);
    chk(32'(err), 1);
    chk(r, 0);
    tally_and_finish();
  end
  // watchdog well beyond the expected run
  initial
  begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule
